// ===== design/evt_route.sv
// Event flags, publish routing, resume subscription, event links and irq of a two-wire master
//
// Contract
// (RULE1) Continue subscription holds 8-bit channel and enable; channel pulse fires continue task.
// (RULE2) Paused flag set once pause accepted and bus traffic held.
// (RULE3) Final-receive-byte flag set when last receive byte starts.
// (RULE4) Final-transmit-byte flag set when last transmit byte starts.
// (RULE5) Halt-done publish config selects channel 0 to 255 for its pulse.
// (RULE6) Publish enable 0 suppresses, 1 forwards pulse; fields reset to zero.
// (RULE7) Fault event has own publish config with channel and enable.
// (RULE8) Paused event has own publish config pulsing its channel.
// (RULE9) Receive-begun event has own publish config pulsing its channel.
// (RULE10) Transmit-begun event has own publish config pulsing its channel.
// (RULE11) Final receive and transmit byte events each have own publish config.
// (RULE12) Five link bits route final-byte events to tasks; reset all disabled.
// (RULE13) Irq enable mask holds one bit per event; 1 permits, 0 blocks.
// (RULE14) Event flags set by hardware, cleared by software writing 0, reset 0.
// (RULE15) Irq output high while any flag and its enable bit are set.
// (RULE16) Halt, fault, rx and tx begun flags set by engine conditions.
`timescale 1ns/1ps
module evt_route #(
   parameter int NUM_CH = 256
) (
   input  wire logic                  clk_in,
   input  wire logic                  nrst_in,
   input  wire logic                  hsel_in,
   input  wire logic [11:0]           haddr_in,
   input  wire logic [1:0]            htrans_in,
   input  wire logic                  hwrite_in,
   input  wire logic [2:0]            hsize_in,
   input  wire logic [31:0]           hwdata_in,
   input  wire logic                  hready_in,
   output logic      [31:0]           hrdata_out,
   output logic                       hreadyout_out,
   output logic                       hresp_out,
   input  wire evt_route_pkg::eng_ev_s eng_ev_in,
   input  wire logic [NUM_CH-1:0]     chan_in,
   output logic      [NUM_CH-1:0]     chan_out,
   output evt_route_pkg::task_s       task_out,
   output logic                       irq_out
);
   localparam int NE = evt_route_pkg::NUM_EV;
   // Bit position of each event in the mask, in flag order
   localparam int EVPOS [NE] = '{evt_route_pkg::EV_HALT, evt_route_pkg::EV_FAULT,
      evt_route_pkg::EV_PAUSED, evt_route_pkg::EV_RXBEGUN, evt_route_pkg::EV_TXBEGUN,
      evt_route_pkg::EV_FINAL_RECEIVE_BYTE_EVENT, evt_route_pkg::EV_FINAL_TRANSMIT_BYTE_EVENT};
   localparam logic [11:0] FLAG_OFF [NE] = '{evt_route_pkg::OFF_HALT_FLAG,
      evt_route_pkg::OFF_FAULT_FLAG, evt_route_pkg::OFF_PAUSED_FLAG,
      evt_route_pkg::OFF_RXBEGUN_FLAG, evt_route_pkg::OFF_TXBEGUN_FLAG,
      evt_route_pkg::OFF_FINAL_RECEIVE_BYTE_EVENT_FLAG, evt_route_pkg::OFF_FINAL_TRANSMIT_BYTE_EVENT_FLAG};
   localparam logic [11:0] PUB_OFF [NE] = '{evt_route_pkg::OFF_HALT_PUB,
      evt_route_pkg::OFF_FAULT_PUB, evt_route_pkg::OFF_PAUSED_PUB,
      evt_route_pkg::OFF_RXBEGUN_PUB, evt_route_pkg::OFF_TXBEGUN_PUB,
      evt_route_pkg::OFF_FINAL_RECEIVE_BYTE_EVENT_PUB, evt_route_pkg::OFF_FINAL_TRANSMIT_BYTE_EVENT_PUB};

   // Bus address-phase capture
   logic                       wr_pend_q, wr_pend_d;
   logic [11:0]                addr_q, addr_d;
   logic [31:0]                rdata_q, rdata_d;
   // Control and state
   logic [NE-1:0]              flag_q, flag_d;
   evt_route_pkg::chan_cfg_s   pub_q [NE];
   evt_route_pkg::chan_cfg_s   pub_d [NE];
   evt_route_pkg::chan_cfg_s   sub_q, sub_d;
   logic [31:0]                links_q, links_d;
   logic [31:0]                mask_q, mask_d;
   // Registered outputs
   logic [NUM_CH-1:0]          chan_q, chan_d;
   evt_route_pkg::task_s       task_q, task_d;
   logic                       irq_q, irq_d;
   // Synchronised channel inputs
   logic [NUM_CH-1:0]          chan_s1_q, chan_s2_q;
   // Bus answer flags, held in flops so every output comes from a register
   logic                       ready_q, resp_q;

   logic [NE-1:0]              ev;
   logic                       acc;
   logic [31:0]                rd_val;

   // Channel lines come from another block's timing, so two flops first
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         chan_s1_q <= '0;
         chan_s2_q <= '0;
      end else begin
         chan_s1_q <= chan_in;
         chan_s2_q <= chan_s1_q;
      end
   end

   // Engine strobes in flag order
   // (RULE2) paused strobe
   // (RULE3) last receive byte strobe
   // (RULE4) last transmit byte strobe
   // (RULE16) engine conditions map to flags
   assign ev = {eng_ev_in.last_tx, eng_ev_in.last_rx, eng_ev_in.tx_begun,
                eng_ev_in.rx_begun, eng_ev_in.paused, eng_ev_in.fault, eng_ev_in.halted};

   assign acc = hsel_in && hready_in && (htrans_in == evt_route_pkg::HTRANS_NONSEQ
                || htrans_in == evt_route_pkg::HTRANS_SEQ);

   // Read mux over the address phase, so data is ready in the data phase
   always_comb begin
      rd_val = evt_route_pkg::RST_ZERO;
      for (int i = 0; i < NE; i++) begin
         if (haddr_in == FLAG_OFF[i]) rd_val = {31'h0, flag_q[i]};
         if (haddr_in == PUB_OFF[i])
            rd_val = {pub_q[i].en, 23'h0, pub_q[i].idx};
      end
      if (haddr_in == evt_route_pkg::OFF_CONT_SUB) rd_val = {sub_q.en, 23'h0, sub_q.idx};
      if (haddr_in == evt_route_pkg::OFF_LINKS) rd_val = links_q;
      if (haddr_in == evt_route_pkg::OFF_IRQ_MASK) rd_val = mask_q;
   end

   // Next state of bus, registers, flags and outputs
   always_comb begin
      wr_pend_d = acc && hwrite_in;
      addr_d    = acc ? haddr_in : addr_q;
      rdata_d   = (acc && !hwrite_in) ? rd_val : evt_route_pkg::RST_ZERO;
      sub_d     = sub_q;
      links_d   = links_q;
      mask_d    = mask_q;
      flag_d    = flag_q;
      for (int i = 0; i < NE; i++) pub_d[i] = pub_q[i];
      // Register writes in the data phase
      if (wr_pend_q) begin
         for (int i = 0; i < NE; i++) begin
            // (RULE14) software writes flag value
            if (addr_q == FLAG_OFF[i]) flag_d[i] = hwdata_in[0];
            // (RULE5) channel index stored
            // (RULE11) separate config per event
            if (addr_q == PUB_OFF[i]) begin
               pub_d[i].idx = hwdata_in[evt_route_pkg::CH_W-1:0];
               pub_d[i].en  = hwdata_in[evt_route_pkg::CFG_EN_BIT];
            end
         end
         // (RULE1) subscription fields stored
         if (addr_q == evt_route_pkg::OFF_CONT_SUB) begin
            sub_d.idx = hwdata_in[evt_route_pkg::CH_W-1:0];
            sub_d.en  = hwdata_in[evt_route_pkg::CFG_EN_BIT];
         end
         if (addr_q == evt_route_pkg::OFF_LINKS) begin
            links_d = '0;
            links_d[evt_route_pkg::LNK_TX_RX]   = hwdata_in[evt_route_pkg::LNK_TX_RX];
            links_d[evt_route_pkg::LNK_TX_PAUS] = hwdata_in[evt_route_pkg::LNK_TX_PAUS];
            links_d[evt_route_pkg::LNK_TX_HALT] = hwdata_in[evt_route_pkg::LNK_TX_HALT];
            links_d[evt_route_pkg::LNK_RX_TX]   = hwdata_in[evt_route_pkg::LNK_RX_TX];
            links_d[evt_route_pkg::LNK_RX_HALT] = hwdata_in[evt_route_pkg::LNK_RX_HALT];
         end
         // (RULE13) one enable bit per event
         if (addr_q == evt_route_pkg::OFF_IRQ_MASK) begin
            mask_d = '0;
            for (int i = 0; i < NE; i++) mask_d[EVPOS[i]] = hwdata_in[EVPOS[i]];
         end
      end
      // (RULE14) hardware set wins over a clearing write
      flag_d = flag_d | ev;

      // Publication: one pulse on the chosen channel per event
      chan_d = '0;
      for (int i = 0; i < NE; i++) begin
         // (RULE6) enable gates publication
         // (RULE7) fault routed by its own config
         // (RULE8) paused routed by its own config
         // (RULE9) receive begun routed
         // (RULE10) transmit begun routed
         if (ev[i] && pub_q[i].en && (32'(pub_q[i].idx) < NUM_CH))
            chan_d[pub_q[i].idx] = 1'b1;
      end

      // (RULE12) event links drive tasks directly
      task_d.begin_receive_task  = ev[6] && links_q[evt_route_pkg::LNK_TX_RX];
      task_d.pause_task          = ev[6] && links_q[evt_route_pkg::LNK_TX_PAUS];
      task_d.halt_task           = (ev[6] && links_q[evt_route_pkg::LNK_TX_HALT])
                                   || (ev[5] && links_q[evt_route_pkg::LNK_RX_HALT]);
      task_d.begin_transmit_task = ev[5] && links_q[evt_route_pkg::LNK_RX_TX];
      // (RULE1) subscribed channel fires continue task
      task_d.continue_task = sub_q.en && (32'(sub_q.idx) < NUM_CH)
                             && chan_s2_q[sub_q.idx];

      // (RULE15) level irq from masked flags
      irq_d = 1'b0;
      for (int i = 0; i < NE; i++) irq_d = irq_d | (flag_d[i] & mask_d[EVPOS[i]]);
   end

   // State registers; all zero out of reset
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         wr_pend_q <= 1'b0;
         addr_q    <= '0;
         rdata_q   <= evt_route_pkg::RST_ZERO;
         flag_q    <= '0;
         for (int i = 0; i < NE; i++) pub_q[i] <= '0;
         sub_q     <= '0;
         links_q   <= evt_route_pkg::RST_ZERO;
         mask_q    <= evt_route_pkg::RST_ZERO;
         chan_q    <= '0;
         task_q    <= '0;
         irq_q     <= 1'b0;
      end else begin
         wr_pend_q <= wr_pend_d;
         addr_q    <= addr_d;
         rdata_q   <= rdata_d;
         flag_q    <= flag_d;
         for (int i = 0; i < NE; i++) pub_q[i] <= pub_d[i];
         sub_q     <= sub_d;
         links_q   <= links_d;
         mask_q    <= mask_d;
         chan_q    <= chan_d;
         task_q    <= task_d;
         irq_q     <= irq_d;
      end
   end

   // Zero-wait slave: always ready, always OKAY
   // Zero-wait answer; ready stays high in reset so the bus never stalls
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         ready_q <= 1'b1;
         resp_q  <= 1'b0;
      end else begin
         ready_q <= 1'b1;
         resp_q  <= 1'b0;
      end
   end

   assign hrdata_out    = rdata_q;
   assign hreadyout_out = ready_q;
   assign hresp_out     = resp_q;
   assign chan_out      = chan_q;
   assign task_out      = task_q;
   assign irq_out       = irq_q;

   // (RULE14) event leaves flag set next cycle
   a_flag_sets_on_event: assert property (@(posedge clk_in) disable iff (!nrst_in)
      ev[0] |=> flag_q[0]) else $error("halt flag not set after event");
   // (RULE2) paused flag follows strobe
   a_paused_flag_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
      eng_ev_in.paused |=> flag_q[2]) else $error("paused flag not set");
   // (RULE3) last receive flag follows strobe
   a_final_receive_byte_event_flag_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
      eng_ev_in.last_rx |=> flag_q[5]) else $error("last rx flag not set");
   // (RULE4) last transmit flag follows strobe
   a_final_transmit_byte_event_flag_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
      eng_ev_in.last_tx |=> flag_q[6]) else $error("last tx flag not set");
   // (RULE6) enabled publish pulses its channel
   a_pub_fault_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (eng_ev_in.fault && pub_q[1].en) |=> chan_out[$past(pub_q[1].idx)])
      else $error("fault not published");
   // (RULE6) no pulse without an event
   a_pub_quiet_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev == '0) |=> (chan_out == '0)) else $error("spurious channel pulse");
   // (RULE12) link to halt task
   a_link_tx_halt: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (eng_ev_in.last_tx && links_q[evt_route_pkg::LNK_TX_HALT]) |=> task_out.halt_task)
      else $error("halt task not triggered");
   // (RULE15) irq tracks masked flags
   a_irq_level_match: assert property (@(posedge clk_in) disable iff (!nrst_in)
      irq_out == |(flag_q & {mask_q[24], mask_q[23], mask_q[20], mask_q[19], mask_q[18],
                             mask_q[9], mask_q[0]})) else $error("irq level mismatch");
   // (RULE1) subscription fires continue task
   a_sub_continue: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (sub_q.en && chan_s2_q[sub_q.idx] && $stable(sub_q)) |=> task_out.continue_task)
      else $error("continue task missed");

   // Further checks on flags, routing, links and the bus answer
   // (RULE16) fault flag follows strobe
   a_fault_flag_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
      eng_ev_in.fault |=> flag_q[1]) else $error("fault flag not set");
   // (RULE16) receive begun flag follows strobe
   a_rxbegun_flag_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
      eng_ev_in.rx_begun |=> flag_q[3]) else $error("rx begun flag not set");
   // (RULE16) transmit begun flag follows strobe
   a_txbegun_flag_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
      eng_ev_in.tx_begun |=> flag_q[4]) else $error("tx begun flag not set");
   // (RULE5) halt-done published on its channel
   a_pub_halt_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[0] && pub_q[0].en) |=> chan_out[$past(pub_q[0].idx)])
      else $error("halt not published");
   // (RULE8) paused published on its channel
   a_pub_paused_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[2] && pub_q[2].en) |=> chan_out[$past(pub_q[2].idx)])
      else $error("paused not published");
   // (RULE9) receive begun published
   a_pub_rxbegun_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[3] && pub_q[3].en) |=> chan_out[$past(pub_q[3].idx)])
      else $error("rx begun not published");
   // (RULE10) transmit begun published
   a_pub_txbegun_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[4] && pub_q[4].en) |=> chan_out[$past(pub_q[4].idx)])
      else $error("tx begun not published");
   // (RULE11) final receive byte published
   a_pub_final_receive_byte_event_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[5] && pub_q[5].en) |=> chan_out[$past(pub_q[5].idx)])
      else $error("last rx not published");
   // (RULE11) final transmit byte published
   a_pub_final_transmit_byte_event_pulse: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[6] && pub_q[6].en) |=> chan_out[$past(pub_q[6].idx)])
      else $error("last tx not published");
   // (RULE12) link to begin receive task
   a_link_tx_rx: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[6] && links_q[evt_route_pkg::LNK_TX_RX]) |=> task_out.begin_receive_task)
      else $error("begin receive task not triggered");
   // (RULE12) link to pause task
   a_link_tx_pause: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[6] && links_q[evt_route_pkg::LNK_TX_PAUS]) |=> task_out.pause_task)
      else $error("pause task not triggered");
   // (RULE12) link to begin transmit task
   a_link_rx_tx: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[5] && links_q[evt_route_pkg::LNK_RX_TX]) |=> task_out.begin_transmit_task)
      else $error("begin transmit task not triggered");
   // (RULE12) receive link to halt task
   a_link_rx_halt: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (ev[5] && links_q[evt_route_pkg::LNK_RX_HALT]) |=> task_out.halt_task)
      else $error("halt task not triggered by rx");
   // (RULE12) no begin receive or pause task without a final-byte event
   a_link_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (!ev[5] && !ev[6]) |=> (!task_out.begin_receive_task && !task_out.pause_task))
      else $error("spurious linked task");
   // (RULE12) only the five link bits can hold a one
   a_links_unused_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (links_q & ~32'h0000_1780) == 32'h0000_0000) else $error("unused link bit set");
   // (RULE13) only event bits of the mask can hold a one
   a_mask_unused_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (mask_q & ~32'h019c_0201) == 32'h0000_0000) else $error("unused mask bit set");
   // (RULE14) clearing write without event leaves flag low
   a_flag_clear_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (wr_pend_q && addr_q == FLAG_OFF[0] && !hwdata_in[0] && !ev[0]) |=> !flag_q[0])
      else $error("halt flag not cleared");
   // (RULE1) disabled subscription never fires continue
   a_cont_sub_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !sub_q.en |=> !task_out.continue_task) else $error("continue task while disabled");
   // Zero-wait slave keeps ready high
   a_bus_ready_high: assert property (@(posedge clk_in) disable iff (!nrst_in)
      hreadyout_out) else $error("ready dropped");
   // Response is always OKAY
   a_bus_resp_okay: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !hresp_out) else $error("error response seen");
   // Read data is zero outside a read data phase
   a_rdata_idle_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !(acc && !hwrite_in) |=> (hrdata_out == 32'h0000_0000))
      else $error("read data outside data phase");
endmodule : evt_route

// ===== design/evt_route_pkg.sv
// Package with register map, field layout and carrier types of the event routing block
package evt_route_pkg;
   // Register byte offsets
   localparam logic [11:0] OFF_HALT_FLAG     = 12'h104;
   localparam logic [11:0] OFF_FAULT_FLAG    = 12'h124;
   localparam logic [11:0] OFF_PAUSED_FLAG   = 12'h148;
   localparam logic [11:0] OFF_RXBEGUN_FLAG  = 12'h14c;
   localparam logic [11:0] OFF_TXBEGUN_FLAG  = 12'h150;
   localparam logic [11:0] OFF_FINAL_RECEIVE_BYTE_EVENT_FLAG   = 12'h15c;
   localparam logic [11:0] OFF_FINAL_TRANSMIT_BYTE_EVENT_FLAG   = 12'h160;
   localparam logic [11:0] OFF_HALT_PUB      = 12'h184;
   localparam logic [11:0] OFF_FAULT_PUB     = 12'h1a4;
   localparam logic [11:0] OFF_PAUSED_PUB    = 12'h1c8;
   localparam logic [11:0] OFF_RXBEGUN_PUB   = 12'h1cc;
   localparam logic [11:0] OFF_TXBEGUN_PUB   = 12'h1d0;
   localparam logic [11:0] OFF_FINAL_RECEIVE_BYTE_EVENT_PUB    = 12'h1dc;
   localparam logic [11:0] OFF_FINAL_TRANSMIT_BYTE_EVENT_PUB    = 12'h1e0;
   localparam logic [11:0] OFF_LINKS         = 12'h200;
   localparam logic [11:0] OFF_IRQ_MASK      = 12'h300;
   localparam logic [11:0] OFF_CONT_SUB      = 12'h0a0;

   // Event index, also the bit of the irq enable mask
   localparam int EV_HALT    = 0;
   localparam int EV_FAULT   = 9;
   localparam int EV_PAUSED  = 18;
   localparam int EV_RXBEGUN = 19;
   localparam int EV_TXBEGUN = 20;
   localparam int EV_FINAL_RECEIVE_BYTE_EVENT  = 23;
   localparam int EV_FINAL_TRANSMIT_BYTE_EVENT  = 24;
   localparam int NUM_EV     = 7;

   // Channel config layout
   localparam int CH_W       = 8;
   localparam int CFG_EN_BIT = 31;

   // Link register bits
   localparam int LNK_TX_RX   = 7;
   localparam int LNK_TX_PAUS = 8;
   localparam int LNK_TX_HALT = 9;
   localparam int LNK_RX_TX   = 10;
   localparam int LNK_RX_HALT = 12;

   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;

   // Channel routing config: enable plus index
   typedef struct packed {
      logic            en;
      logic [CH_W-1:0] idx;
   } chan_cfg_s;

   // Engine condition strobes
   typedef struct packed {
      logic halted;
      logic fault;
      logic paused;
      logic rx_begun;
      logic tx_begun;
      logic last_rx;
      logic last_tx;
   } eng_ev_s;

   // Task strobes toward the engine
   typedef struct packed {
      logic begin_receive_task;
      logic begin_transmit_task;
      logic pause_task;
      logic halt_task;
      logic continue_task;
   } task_s;
endpackage : evt_route_pkg

// ===== test/eng_model.sv
// Far-side model: bus engine condition strobes and routing fabric pulses
`timescale 1ns/1ps
module eng_model (
   input  wire logic                   clk_in,
   output evt_route_pkg::eng_ev_s      ev_out,
   output logic [255:0]                ch_out
);
   // Fabric and engine lines idle low between pulses
   initial begin
      ev_out = '0;
      ch_out = '0;
   end

   // engine conditions
   // One-cycle strobe; k of 7 or more gives a fabric pulse only
   task fire(input int k, input logic [255:0] ch);
      @(posedge clk_in);
      ev_out <= evt_route_pkg::eng_ev_s'(7'h40 >> k);
      ch_out <= ch;
      @(posedge clk_in);
      ev_out <= '0;
      ch_out <= '0;
   endtask : fire
endmodule : eng_model

// ===== test/two_wire_master_event_routing_bench.sv
// Self-checking bench for the event routing block
`timescale 1ns/1ps
module two_wire_master_event_routing_bench;
   logic                    clk_in;
   logic                    nrst_in;
   logic                    hsel;
   logic [11:0]             haddr;
   logic [1:0]              htrans;
   logic                    hwrite;
   logic [31:0]             hwdata;
   logic [31:0]             hrdata;
   logic                    hrdy;
   logic                    hresp;
   evt_route_pkg::eng_ev_s  ev;
   logic [255:0]            ch_in;
   logic [255:0]            chan_out;
   evt_route_pkg::task_s    task_out;
   logic                    irq;
   int                      err_count;
   int                      n_compared;
   logic [31:0]             d;
   logic [31:0]             c;
   logic [7:0]              idx;
   logic [255:0]            chq[$];
   logic [4:0]              tq[$];
   logic [11:0] flg[7] = '{12'h104, 12'h124, 12'h148, 12'h14c, 12'h150, 12'h15c, 12'h160};
   logic [11:0] pub[7] = '{12'h184, 12'h1a4, 12'h1c8, 12'h1cc, 12'h1d0, 12'h1dc, 12'h1e0};
   int          mb[7]  = '{0, 9, 18, 19, 20, 23, 24};

   evt_route i_dut (
      .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .eng_ev_in(ev), .chan_in(ch_in), .chan_out(chan_out), .task_out(task_out),
      .irq_out(irq)
   );

   eng_model i_eng (.clk_in(clk_in), .ev_out(ev), .ch_out(ch_in));

   // Free-running 100 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // Record every pulse so that missing and extra pulses both show
   always @(posedge clk_in) begin
      if (chan_out != 0) chq.push_back(chan_out);
      if (task_out != 0) tq.push_back(task_out);
   end

   task chk(input logic [255:0] g, input logic [255:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Address phase held until hready, then data phase until hready
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk_in);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= evt_route_pkg::HTRANS_NONSEQ;
      do @(posedge clk_in); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_in); while (hrdy !== 1'b1);
      d = hrdata;
      chk(hresp, 0);
   endtask : xfer

   task wr(input logic [11:0] a, input logic [31:0] wd);
      xfer(a, 1'b1, wd);
   endtask : wr

   task rd(input logic [11:0] a);
      xfer(a, 1'b0, 32'h0);
   endtask : rd

   // Wait out the pulse latency, then compare captured pulses
   task expq(input int n, input logic [255:0] e1, input logic [4:0] e2);
      repeat (n) @(posedge clk_in);
      chk(chq.size(), (e1 != 0));
      if (chq.size() != 0) chk(chq[0], e1);
      chk(tq.size(), (e2 != 0));
      if (tq.size() != 0) chk(tq[0], e2);
      chq.delete();
      tq.delete();
   endtask : expq

   task wrap_up;
      if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // Hang guard; the full run needs well under 40 us
   initial begin
      #200us;
      err_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      nrst_in = 1'b0;
      hsel = 1'b0;
      haddr = 12'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      err_count = 0;
      n_compared = 0;
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      void'($urandom(32'h17d48b17));
      for (int i = 0; i < 7; i++) begin
         rd(flg[i]);
         chk(d, 0);
         rd(pub[i]);
         chk(d, 0);
      end
      rd(evt_route_pkg::OFF_LINKS);
      chk(d, 0);
      rd(evt_route_pkg::OFF_IRQ_MASK);
      chk(d, 0);
      rd(12'h004);
      chk(d, 0);
      // each event, enable 1 for odd k and 0 for even k
      for (int k = 0; k < 7; k++) begin
         idx = 8'($urandom % 256);
         c = {k[0], 23'h0, idx};
         wr(pub[k], c);
         rd(pub[k]);
         chk(d, c);
         wr(evt_route_pkg::OFF_IRQ_MASK, 32'h1 << mb[k]);
         i_eng.fire(k, '0);
         expq(4, c[31] ? (256'h1 << idx) : '0, 5'h0);
         rd(flg[k]);
         chk(d, 1);
         chk(irq, 1);
         wr(evt_route_pkg::OFF_IRQ_MASK, 32'h0);
         rd(flg[k]);
         chk(irq, 0);
         wr(flg[k], 32'h0);
         rd(flg[k]);
         chk(d, 0);
         wr(pub[k], 32'h0);
      end
      // all five links, final-byte events to tasks
      wr(evt_route_pkg::OFF_LINKS, 32'h0000_1780);
      rd(evt_route_pkg::OFF_LINKS);
      chk(d, 32'h0000_1780);
      i_eng.fire(6, '0);
      expq(4, '0, 5'b10110);
      i_eng.fire(5, '0);
      expq(4, '0, 5'b01010);
      wr(evt_route_pkg::OFF_LINKS, 32'h0);
      idx = 8'($urandom % 256);
      wr(evt_route_pkg::OFF_CONT_SUB, {1'b1, 23'h0, idx});
      rd(evt_route_pkg::OFF_CONT_SUB);
      chk(d, {1'b1, 23'h0, idx});
      i_eng.fire(7, 256'h1 << idx);
      expq(6, '0, 5'b00001);
      wr(evt_route_pkg::OFF_CONT_SUB, {24'h0, idx});
      i_eng.fire(7, 256'h1 << idx);
      expq(6, '0, 5'b00000);
      wrap_up();
   end
endmodule : two_wire_master_event_routing_bench
